// >>> pim_device.sv
// Sixteen-level fixed-priority interrupt controller.
// Assumes asynchronous source pins, one clock, and a processor end
// on the link that loads masks and acknowledges served levels.
//
// Function
// - Sixteen levels, level 0 ranks highest
// - Power-down level 0 always delivered
// - Machine error ignores disable, obeys mask
// - Executive call level 5 always delivered
// - Levels 8, 10, 13 take unit sources
// - Timer A raises level 7
// - Timer B raises level 9
// - I/O on 12 and 14; 2,11,15 idle
// - Sixteen-bit mask, level 0 at top
// - Software loads D5E4 for runtime code
// - Software loads DD40 during elaboration
// - Software loads DDE4 for task execution
// - Software applies DC00 against pre-emption
// - Connect mask 0100 allows level 7 besides always-delivered levels 0 and 5
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`include "pim_params.svh"

module pim_device
   import pim_pkg::*;
(
   input  wire logic    mclk_i,
   input  wire logic    rst_i,
   input  wire logic    ce_i,
   input  wire logic    power_down_i,
   input  wire logic    machine_error_i,
   input  wire logic    fp_overflow_i,
   input  wire logic    fixed_overflow_i,
   input  wire logic    exec_call_i,
   input  wire logic    fp_underflow_i,
   input  wire logic    timer_a_i,
   input  wire logic    onboard_bus_port_irq_i,
   input  wire logic    timer_b_i,
   input  wire logic    sync_serial_link_irq_i,
   input  wire logic    io_level1_i,
   input  wire logic    user_instr_i,
   input  wire logic    remote_bus_link_i,
   input  wire logic    loss_of_signal_i,
   input  wire logic    io_level2_i,
   pim_link_if.dev      link,
   output pim_vec_type  pending_o,
   output pim_vec_type  enabled_o
);

   // Mask bit for level n sits at position 15-n
   function automatic pim_vec_type mask_to_levels(input pim_vec_type m);
      pim_vec_type v;
      v = '0;
      for (int i = 0; i < `PIM_NUM_LEVELS; i++) begin
         v[i] = m[`PIM_NUM_LEVELS-1-i];
      end
      return v;
   endfunction

   // Per-level enable after mask and global disable
   function automatic pim_vec_type level_enables(input pim_vec_type m,
                                                 input logic dis);
      pim_vec_type lv;
      pim_vec_type e;
      lv = mask_to_levels(m);
      for (int i = 0; i < `PIM_NUM_LEVELS; i++) begin
         e[i] = lv[i] & ~dis;
      end
      e[`PIM_LVL_POWER_DOWN] = 1'b1;
      e[`PIM_LVL_EXEC_CALL] = 1'b1;
      e[`PIM_LVL_MACH_ERR] = lv[`PIM_LVL_MACH_ERR];
      return e;
   endfunction

   // Lowest-numbered set bit wins
   function automatic pim_level_type first_set(input pim_vec_type v);
      pim_level_type l;
      l = '0;
      for (int i = `PIM_NUM_LEVELS - 1; i >= 0; i--) begin
         if (v[i]) begin
            l = pim_level_type'(i);
         end
      end
      return l;
   endfunction

   // One-hot vector of one level
   function automatic pim_vec_type level_bit(input pim_level_type l);
      pim_vec_type v;
      v = '0;
      v[l] = 1'b1;
      return v;
   endfunction

   pim_vec_type   raw;
   pim_vec_type   sync1;
   pim_vec_type   sync2;
   pim_vec_type   prev;
   pim_vec_type   pending;
   pim_vec_type   next_sync1;
   pim_vec_type   next_sync2;
   pim_vec_type   next_prev;
   pim_vec_type   next_pending;
   pim_vec_type   rise;
   pim_vec_type   clr;
   pim_vec_type   en;
   pim_vec_type   eligible;
   logic          irq_valid;
   pim_level_type irq_level;
   pim_vec_type   enabled;
   logic          next_irq_valid;
   pim_level_type next_irq_level;
   pim_vec_type   next_enabled;

   // Source wiring onto levels; spare levels stay low.
   // Level 13 merges three sources: software must ask each
   // source which one fired, since an edge of any one marks it while the other two are low.
   // A source held high marks its level once only; it must
   // fall and rise again to be seen a second time.
   always_comb begin
      raw = '0;
      raw[`PIM_LVL_POWER_DOWN] = power_down_i;
      raw[`PIM_LVL_MACH_ERR] = machine_error_i;
      raw[`PIM_LVL_FP_OVF] = fp_overflow_i;
      raw[`PIM_LVL_FIX_OVF] = fixed_overflow_i;
      raw[`PIM_LVL_EXEC_CALL] = exec_call_i;
      raw[`PIM_LVL_FP_UNF] = fp_underflow_i;
      raw[`PIM_LVL_TIMER_A] = timer_a_i;
      raw[`PIM_LVL_BUS_PORT] = onboard_bus_port_irq_i;
      raw[`PIM_LVL_TIMER_B] = timer_b_i;
      raw[`PIM_LVL_SER_LINK] = sync_serial_link_irq_i;
      raw[`PIM_LVL_IO1] = io_level1_i;
      raw[`PIM_LVL_USER] = user_instr_i
                         | remote_bus_link_i
                         | loss_of_signal_i;
      raw[`PIM_LVL_IO2] = io_level2_i;
   end

   // Two-stage synchroniser and edge history.
   // Only the second stage feeds the edge detector; history
   // starts low, matching the idle level of every source,
   // so leaving reset raises no false edge.
   always_comb begin
      next_sync1 = raw;
      next_sync2 = sync1;
      next_prev  = sync2;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sync1 <= '0;
         sync2 <= '0;
         prev  <= '0;
      end else if (ce_i) begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         prev  <= next_prev;
      end
   end

   // Rising edge of a source marks its level pending
   assign rise = sync2 & ~prev;

   // Acknowledge clears one level; a new edge wins.
   // An ack of a level that is not pending changes nothing.
   // An edge landing in its own ack cycle keeps the level
   // pending, so no request is ever lost.
   always_comb begin
      clr = '0;
      if (link.ack) begin
         clr = level_bit(link.ack_level);
      end
      next_pending = (pending & ~clr) | rise;
   end

   // Enable gating and priority pick on the next pending set.
   // Built from the next pending set so an ack leaves no stale
   // cycle on the link; a masked level simply waits, pending,
   // until software enables it again.
   always_comb begin
      en             = level_enables(link.mask, link.global_dis);
      eligible       = next_pending & en;
      next_irq_valid = |eligible;
      next_irq_level = first_set(eligible);
      next_enabled   = en;
   end

   // Pending latch and presented request
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pending   <= '0;
         irq_valid <= 1'b0;
         irq_level <= '0;
         enabled   <= '0;
      end else if (ce_i) begin
         pending   <= next_pending;
         irq_valid <= next_irq_valid;
         irq_level <= next_irq_level;
         enabled   <= next_enabled;
      end
   end

   // Registered outputs
   assign link.irq_valid = irq_valid;
   assign link.irq_level = irq_level;
   assign pending_o      = pending;
   assign enabled_o      = enabled;

endmodule

// >>> pim_params.svh
// Constants shared by the interrupt controller and its processor end.
// Assumes inclusion by bare name from the package and both modules.
`ifndef PIM_PARAMS_SVH
`define PIM_PARAMS_SVH

// Level count and level index width
`define PIM_NUM_LEVELS     16
`define PIM_LVL_W          4

// Level numbers of each source
`define PIM_LVL_POWER_DOWN 4'h0
`define PIM_LVL_MACH_ERR   4'h1
`define PIM_LVL_FP_OVF     4'h3
`define PIM_LVL_FIX_OVF    4'h4
`define PIM_LVL_EXEC_CALL  4'h5
`define PIM_LVL_FP_UNF     4'h6
`define PIM_LVL_TIMER_A    4'h7
`define PIM_LVL_BUS_PORT   4'h8
`define PIM_LVL_TIMER_B    4'h9
`define PIM_LVL_SER_LINK   4'ha
`define PIM_LVL_IO1        4'hc
`define PIM_LVL_USER       4'hd
`define PIM_LVL_IO2        4'he

// Preset enable masks, level 0 in the top bit
`define PIM_MASK_RUNTIME   16'hd5e4
`define PIM_MASK_ELAB      16'hdd40
`define PIM_MASK_TASK      16'hdde4
`define PIM_MASK_PREEMPT   16'hdc00
`define PIM_MASK_CONNECT   16'h0100

// Control reset values
`define PIM_MASK_RESET     16'h0000
`define PIM_DIS_RESET      1'b1

// Register word addresses
`define PIM_ADDR_W         3
`define PIM_REG_CTRL       3'h0
`define PIM_REG_PRESET     3'h1
`define PIM_REG_STATUS     3'h2
`define PIM_REG_ACK        3'h3
`define PIM_REG_EV_STAT    3'h4
`define PIM_REG_EV_MASK    3'h5

// Field positions
`define PIM_CTRL_DIS_BIT   16
`define PIM_STAT_VALID_BIT 0
`define PIM_STAT_LVL_LSB   4
`define PIM_PRESET_W       3
`define PIM_EV_W           2
`define PIM_EV_REQ         0
`define PIM_EV_PD          1
`define PIM_EV_RESET       2'h0
`define PIM_DATA_W         32

`endif

// >>> pim_pkg.sv
// Types shared by both ends of the interrupt controller.
// Assumes the constants header sits in the same folder.
`include "pim_params.svh"

package pim_pkg;
   typedef logic [`PIM_NUM_LEVELS-1:0] pim_vec_type;
   typedef logic [`PIM_LVL_W-1:0]      pim_level_type;
   typedef logic [`PIM_EV_W-1:0]       pim_ev_type;
   typedef logic [`PIM_DATA_W-1:0]     pim_word_type;
   // Selectable preset masks
   typedef enum logic [`PIM_PRESET_W-1:0] {
      pim_preset_runtime,
      pim_preset_elab,
      pim_preset_task,
      pim_preset_preempt,
      pim_preset_connect
   } pim_preset_type;
endpackage

// >>> pim_link_if.sv
// Link between the interrupt controller and the processor end.
// Assumes both ends run on one clock; the bench instantiates it.
interface pim_link_if;
   import pim_pkg::*;
   pim_vec_type   mask;
   logic          global_dis;
   logic          ack;
   pim_level_type ack_level;
   logic          irq_valid;
   pim_level_type irq_level;

   // Controller side
   modport dev (
      input  mask,
      input  global_dis,
      input  ack,
      input  ack_level,
      output irq_valid,
      output irq_level
   );

   // Processor side
   modport cpu (
      output mask,
      output global_dis,
      output ack,
      output ack_level,
      input  irq_valid,
      input  irq_level
   );
endinterface

// >>> pim_cpu_end.sv
// Processor end of the interrupt controller link.
// Assumes an Avalon-MM master on the same clock and the controller
// on the link; software loads masks and acknowledges levels here.
`include "pim_params.svh"

module pim_cpu_end
   import pim_pkg::*;
(
   input  wire logic                   mclk_i,
   input  wire logic                   rst_i,
   input  wire logic                   ce_i,
   input  wire logic [`PIM_ADDR_W-1:0] avs_address_i,
   input  wire logic                   avs_read_i,
   input  wire logic                   avs_write_i,
   input  wire pim_word_type           avs_writedata_i,
   output pim_word_type                avs_readdata_o,
   output logic                        avs_waitrequest_o,
   output logic                        irq_o,
   pim_link_if.cpu                     link
);

   // Preset selection to mask value
   function automatic pim_vec_type preset_value(input pim_preset_type p,
                                                input pim_vec_type old);
      pim_vec_type v;
      v = old;
      unique case (p)
         pim_preset_runtime: v = `PIM_MASK_RUNTIME;
         pim_preset_elab:    v = `PIM_MASK_ELAB;
         pim_preset_task:    v = `PIM_MASK_TASK;
         pim_preset_preempt: v = `PIM_MASK_PREEMPT;
         pim_preset_connect: v = `PIM_MASK_CONNECT;
         default:            v = old;
      endcase
      return v;
   endfunction

   pim_vec_type   mask;
   logic          dis;
   logic          ack;
   pim_level_type ack_level;
   logic          waitreq;
   pim_word_type  rdata;
   pim_ev_type    ev;
   pim_ev_type    ev_mask;
   logic          irq;
   logic          prev_valid;
   pim_level_type prev_level;
   pim_vec_type   next_mask;
   logic          next_dis;
   logic          next_ack;
   pim_level_type next_ack_level;
   logic          next_waitreq;
   pim_word_type  next_rdata;
   pim_ev_type    next_ev;
   pim_ev_type    next_ev_mask;
   logic          next_irq;
   pim_ev_type    ev_set;
   logic          accept;
   logic          done;
   logic          wr;

   // Bus handshake: one wait cycle, then the completing edge
   assign accept = (avs_read_i | avs_write_i) & waitreq;
   assign done   = (avs_read_i | avs_write_i) & ~waitreq;
   assign wr     = done & avs_write_i;

   // Events: new request presented, power-down presented
   always_comb begin
      ev_set = '0;
      if (link.irq_valid & (~prev_valid | (link.irq_level != prev_level))) begin
         ev_set[`PIM_EV_REQ] = 1'b1;
         ev_set[`PIM_EV_PD]  = (link.irq_level == `PIM_LVL_POWER_DOWN);
      end
   end

   // Register file next values
   always_comb begin
      next_mask      = mask;
      next_dis       = dis;
      next_ack       = 1'b0;
      next_ack_level = ack_level;
      next_ev_mask   = ev_mask;
      next_ev        = ev;
      next_waitreq   = ~accept;
      next_rdata     = rdata;
      if (wr) begin
         unique case (avs_address_i)
            `PIM_REG_CTRL: begin
               next_mask = avs_writedata_i[`PIM_NUM_LEVELS-1:0];
               next_dis  = avs_writedata_i[`PIM_CTRL_DIS_BIT];
            end
            `PIM_REG_PRESET: begin
               next_mask = preset_value(
                  pim_preset_type'(avs_writedata_i[`PIM_PRESET_W-1:0]), mask);
            end
            `PIM_REG_ACK: begin
               next_ack       = 1'b1;
               next_ack_level = avs_writedata_i[`PIM_LVL_W-1:0];
            end
            `PIM_REG_EV_STAT: next_ev = ev & ~avs_writedata_i[`PIM_EV_W-1:0];
            `PIM_REG_EV_MASK: next_ev_mask = avs_writedata_i[`PIM_EV_W-1:0];
            default: ;
         endcase
      end
      next_ev = next_ev | ev_set; // Set wins over clear
      if (accept & avs_read_i) begin
         next_rdata = '0;
         unique case (avs_address_i)
            `PIM_REG_CTRL: begin
               next_rdata[`PIM_NUM_LEVELS-1:0] = mask;
               next_rdata[`PIM_CTRL_DIS_BIT]   = dis;
            end
            `PIM_REG_STATUS: begin
               next_rdata[`PIM_STAT_VALID_BIT] = link.irq_valid;
               next_rdata[`PIM_STAT_LVL_LSB +: `PIM_LVL_W] = link.irq_level;
            end
            `PIM_REG_EV_STAT: next_rdata[`PIM_EV_W-1:0] = ev;
            `PIM_REG_EV_MASK: next_rdata[`PIM_EV_W-1:0] = ev_mask;
            default: next_rdata = '0;
         endcase
      end
      next_irq = |(next_ev & next_ev_mask);
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         mask       <= `PIM_MASK_RESET;
         dis        <= `PIM_DIS_RESET;
         ack        <= 1'b0;
         ack_level  <= '0;
         waitreq    <= 1'b1;
         rdata      <= '0;
         ev         <= `PIM_EV_RESET;
         ev_mask    <= `PIM_EV_RESET;
         irq        <= 1'b0;
         prev_valid <= 1'b0;
         prev_level <= '0;
      end else if (ce_i) begin
         mask       <= next_mask;
         dis        <= next_dis;
         ack        <= next_ack;
         ack_level  <= next_ack_level;
         waitreq    <= next_waitreq;
         rdata      <= next_rdata;
         ev         <= next_ev;
         ev_mask    <= next_ev_mask;
         irq        <= next_irq;
         prev_valid <= link.irq_valid;
         prev_level <= link.irq_level;
      end
   end

   // Registered outputs
   assign link.mask         = mask;
   assign link.global_dis   = dis;
   assign link.ack          = ack;
   assign link.ack_level    = ack_level;
   assign avs_readdata_o    = rdata;
   assign avs_waitrequest_o = waitreq;
   assign irq_o             = irq;

endmodule

// >>> pim_link_asserts.sv
// Link checker for the interrupt controller.
// Assumes the bench wires it beside the link interface.
module pim_link_asserts
   import pim_pkg::*;
(
   input wire logic          mclk_i,
   input wire logic          rst_i,
   input wire pim_vec_type   mask_i,
   input wire logic          global_dis_i,
   input wire logic          ack_i,
   input wire pim_level_type ack_level_i,
   input wire logic          irq_valid_i,
   input wire pim_level_type irq_level_i
);
   pim_vec_type mask_q;
   logic        dis_q;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   // Controls as seen one edge earlier
   always_ff @(posedge mclk_i) begin
      mask_q <= mask_i;
      dis_q <= global_dis_i;
   end

   property p_spare;
      irq_valid_i |-> !(irq_level_i inside {4'h2, 4'hb, 4'hf});
   endproperty
   a_spare: assert property (p_spare) else $error("spare level presented");

   property p_lvl1;
      irq_valid_i && irq_level_i == 4'h1 |-> mask_q[14];
   endproperty
   a_lvl1: assert property (p_lvl1) else $error("level 1 shown while masked");

   property p_gated;
      irq_valid_i && !(irq_level_i inside {4'h0, 4'h1, 4'h5})
         |-> mask_q[4'hf - irq_level_i] && !dis_q;
   endproperty
   a_gated: assert property (p_gated) else $error("gated level shown");

   property p_pulse;
      ack_i |=> !ack_i;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");

   property p_drop;
      ack_i && irq_valid_i && ack_level_i == irq_level_i
         |=> !irq_valid_i || irq_level_i != $past(irq_level_i);
   endproperty
   a_drop: assert property (p_drop) else $error("acked level still shown");

   property p_hold;
      irq_valid_i && !ack_i && mask_i == mask_q && global_dis_i == dis_q
         |=> irq_valid_i && irq_level_i <= $past(irq_level_i);
   endproperty
   a_hold: assert property (p_hold) else $error("lower level took over");

   property p_keep;
      irq_valid_i && irq_level_i inside {4'h0, 4'h5} && !ack_i
         |=> irq_valid_i && irq_level_i <= $past(irq_level_i);
   endproperty
   a_keep: assert property (p_keep) else $error("exempt level suppressed");

   property p_one;
      irq_valid_i && irq_level_i == 4'h1 && !ack_i && mask_i[14]
         |=> irq_valid_i && irq_level_i <= 4'h1;
   endproperty
   a_one: assert property (p_one) else $error("level 1 lost to disable");
endmodule

// >>> test_priority_interrupt_masking.sv
// Bench for the interrupt controller and its processor end.
// Assumes both ends meet on the link and share one clock.
`include "pim_params.svh"

module test_priority_interrupt_masking
   import pim_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic         mclk_i   = 1'h0;
   logic         rst_i    = 1'h1;
   logic         ce       = 1'h1;
   logic [15:0]  pin      = 16'h0;
   logic         rbl      = 1'h0;
   logic         los      = 1'h0;
   logic [2:0]   adr      = 3'h0;
   logic         rd       = 1'h0;
   logic         wr       = 1'h0;
   pim_word_type wdat     = 32'h0;
   pim_word_type rdat;
   pim_word_type got;
   logic         wait_r;
   logic         irq;
   pim_vec_type  pend;
   pim_vec_type  en;
   int           errors   = 0;
   int           compares = 0;

   // Clock at 125 MHz
   always #4 mclk_i = ~mclk_i;

   pim_link_if pim_link_if_i();

   pim_device pim_device_i (
      .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
      .power_down_i(pin[0]), .machine_error_i(pin[1]),
      .fp_overflow_i(pin[3]), .fixed_overflow_i(pin[4]),
      .exec_call_i(pin[5]), .fp_underflow_i(pin[6]), .timer_a_i(pin[7]),
      .onboard_bus_port_irq_i(pin[8]), .timer_b_i(pin[9]),
      .sync_serial_link_irq_i(pin[10]), .io_level1_i(pin[12]),
      .user_instr_i(pin[13]), .remote_bus_link_i(rbl),
      .loss_of_signal_i(los), .io_level2_i(pin[14]),
      .link(pim_link_if_i), .pending_o(pend), .enabled_o(en)
   );

   pim_cpu_end pim_cpu_end_i (
      .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wait_r), .irq_o(irq), .link(pim_link_if_i)
   );

   pim_link_asserts pim_link_asserts_i (
      .mclk_i(mclk_i), .rst_i(rst_i), .mask_i(pim_link_if_i.mask),
      .global_dis_i(pim_link_if_i.global_dis), .ack_i(pim_link_if_i.ack),
      .ack_level_i(pim_link_if_i.ack_level),
      .irq_valid_i(pim_link_if_i.irq_valid),
      .irq_level_i(pim_link_if_i.irq_level)
   );

   // Verdict and end of run
   task automatic complete_run();
      if (errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input pim_word_type g, input pim_word_type e, input string m);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   // One bus transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [2:0] a, input pim_word_type d);
      int n;
      n = 0;
      @(posedge mclk_i);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge mclk_i);
         n++;
      end while (wait_r !== 1'h0 && n < 50);
      if (n >= 50) begin
         errors++;
         $display("BAD %0t bus timeout", $time);
         complete_run();
      end
      got = rdat;
      wr <= 1'h0;
      rd <= 1'h0;
   endtask

   task automatic rd_chk(input logic [2:0] a, input pim_word_type e, input string m);
      bus(1'h0, a, 32'h0);
      chk(got, e, m);
   endtask

   task automatic fire(input int l);
      pin[l] <= 1'h1;
      tick(1);
      pin[l] <= 1'h0;
      tick(4);
   endtask

   task automatic ack(input int l);
      bus(1'h1, `PIM_REG_ACK, 32'(l));
      tick(2);
   endtask

   // Levels enabled by a mask and the disable, exempt levels kept
   function automatic pim_vec_type en_exp(input pim_vec_type m, input logic d);
      pim_vec_type r;
      for (int n = 0; n < 16; n++) begin
         r[n] = m[15-n] && (!d || n == 1);
      end
      r[0] = 1'h1;
      r[5] = 1'h1;
      return r;
   endfunction

   task automatic s_reset();
      chk(pend, 32'h0, "pending");
      chk(en, 32'h0021, "enabled");
      rd_chk(`PIM_REG_CTRL, 32'h0001_0000, "ctrl");
      rd_chk(3'h7, 32'h0, "unmapped");
      chk(irq, 32'h0, "irq");
   endtask

   task automatic s_exempt();
      fire(7);
      fire(0);
      rd_chk(`PIM_REG_STATUS, 32'h01, "lvl0");
      fire(5);
      chk(pend, 32'h00a1, "pend");
      ack(0);
      rd_chk(`PIM_REG_STATUS, 32'h51, "lvl5");
      ack(5);
      rd_chk(`PIM_REG_STATUS, 32'h0, "masked");
      bus(1'h1, `PIM_REG_CTRL, 32'h0001_4000);
      fire(1);
      rd_chk(`PIM_REG_STATUS, 32'h11, "lvl1");
      chk(en, en_exp(16'h4000, 1'h1), "en1");
      ack(1);
   endtask

   task automatic s_presets();
      pim_vec_type tbl[5] = '{16'hd5e4, 16'hdd40, 16'hdde4, 16'hdc00, 16'h0100};
      bus(1'h1, `PIM_REG_CTRL, 32'h0);
      for (int i = 0; i < 5; i++) begin
         bus(1'h1, `PIM_REG_PRESET, 32'(i));
         tick(2);
         rd_chk(`PIM_REG_CTRL, 32'(tbl[i]), "preset");
         chk(en, en_exp(tbl[i], 1'h0), "en");
      end
      bus(1'h1, `PIM_REG_PRESET, 32'h5);
      rd_chk(`PIM_REG_CTRL, 32'h0100, "keep");
      rd_chk(`PIM_REG_STATUS, 32'h71, "lvl7");
      ack(7);
   endtask

   task automatic s_map();
      int lv[13] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10, 12, 13, 14};
      bus(1'h1, `PIM_REG_CTRL, 32'h0000_ffff);
      for (int i = 0; i < 13; i++) begin
         fire(lv[i]);
         chk(pend, 32'h1 << lv[i], "map");
         ack(lv[i]);
      end
      rbl <= 1'h1;
      tick(5);
      chk(pend, 32'h2000, "remote");
      rbl <= 1'h0;
      ack(13);
      los <= 1'h1;
      tick(5);
      chk(pend, 32'h2000, "loss");
      los <= 1'h0;
      ack(13);
      pin <= 16'h77fb;
      tick(1);
      pin <= 16'h0;
      tick(4);
      chk(pend, 32'h77fb, "all");
      for (int i = 0; i < 13; i++) begin
         rd_chk(`PIM_REG_STATUS, 32'(lv[i] * 16 + 1), "order");
         ack(lv[i]);
      end
      rd_chk(`PIM_REG_STATUS, 32'h0, "idle");
   endtask

   task automatic s_irq();
      bus(1'h1, `PIM_REG_EV_MASK, 32'h3);
      bus(1'h1, `PIM_REG_EV_STAT, 32'h3);
      fire(0);
      rd_chk(`PIM_REG_EV_STAT, 32'h3, "events");
      chk(irq, 32'h1, "irq on");
      bus(1'h1, `PIM_REG_EV_MASK, 32'h0);
      tick(2);
      chk(irq, 32'h0, "irq masked");
      bus(1'h1, `PIM_REG_EV_MASK, 32'h3);
      tick(2);
      chk(irq, 32'h1, "irq back");
      ack(0);
      bus(1'h1, `PIM_REG_EV_STAT, 32'h3);
      tick(2);
      chk(irq, 32'h0, "irq clear");
      rd_chk(`PIM_REG_EV_STAT, 32'h0, "ev empty");
   endtask

   // Disable alone, level 1 mask, clock enable freeze, mid-run reset
   task automatic s_gate();
      bus(1'h1, `PIM_REG_CTRL, 32'h0001_ffff);
      fire(9);
      chk(pend, 32'h0200, "dis pend");
      chk(en, en_exp(16'hffff, 1'h1), "dis en");
      rd_chk(`PIM_REG_STATUS, 32'h0, "dis");
      bus(1'h1, `PIM_REG_CTRL, 32'h0000_bfff);
      fire(1);
      chk(pend, 32'h0202, "lvl1 pend");
      rd_chk(`PIM_REG_STATUS, 32'h91, "lvl1 masked");
      ce <= 1'h0;
      fire(3);
      ce <= 1'h1;
      tick(4);
      chk(pend, 32'h0202, "frozen");
      rd_chk(`PIM_REG_STATUS, 32'h91, "after freeze");
      rst_i <= 1'h1;
      tick(2);
      rst_i <= 1'h0;
      tick(2);
      chk(pend, 32'h0, "reset pend");
      chk(en, 32'h0021, "reset en");
      rd_chk(`PIM_REG_CTRL, 32'h0001_0000, "reset ctrl");
   endtask

   // Main sequence
   initial begin
      tick(2);
      rst_i <= 1'h0;
      tick(2);
      s_reset();
      s_exempt();
      s_presets();
      s_map();
      s_irq();
      s_gate();
      complete_run();
   end
endmodule
